/* core/asa_core.sv */
`timescale 1ns/1ps
// Async serial adapter: register pair, transmitter, modem lines, status
//
// Functional notes
// - Transmit line changes only on transmit clock fall
// - Receive line sampled on receive clock rise
// - Ratios 16 and 64 align to start edge
// - Clear-to-send high hides transmit empty flag
// - Status bit 3 mirrors clear-to-send input
// - Request-to-send driven from transmit control field
// - Carrier loss holds receiver in initial state
// - Carrier loss rise interrupts when receive enabled
// - Select low: read status, write control
// - Bit 0 first; unused receive bits zero
// - Receive full set on transfer, cleared reading
// - Transmit empty low after write until the shifter takes the byte
// - Carrier status latches until status, data read
// - Framing fault from missing first stop bit
// - Overrun shown after prior read, cleared reading
// - Parity fault held while character remains
// - Status bit 7 shows interrupt output state
// - Control bits 1:0 choose divide or reset
// - Master reset clears status flags but sets transmit empty; initialises both sections
// - Control bits 4:2 choose character format
// - Write-only control byte; bit 7 receive enable
// - Select high: read receive, write transmit
// - Transmit control encodes request, interrupt, break
// - Receive enable gates full and carrier interrupts
// - Frame is start, data, parity, stop bits
module asa_core (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       bus_strobe,
  input  wire logic       chip_select_0,
  input  wire logic       chip_select_1,
  input  wire logic       chip_select_2_n,
  input  wire logic       read_not_write,
  input  wire logic       register_select_line,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  output logic            irq_out,
  output logic            irq_oe_n,
  input  wire logic       transmit_bit_clock,
  input  wire logic       receive_bit_clock,
  input  wire logic       rxd,
  output logic            txd,
  input  wire logic       clear_to_send_n,
  output logic            request_to_send_n,
  input  wire logic       carrier_present_input_n
);

  logic [4:0]        pin_1_q;
  logic [4:0]        pin_2_q;
  logic [4:0]        pin_3_q;
  logic              tx_fall;
  logic              rx_rise;
  logic              car_rise;
  logic              cts_s;
  logic              car_s;
  logic              sel;
  logic              rd_stat;
  logic              rd_data;
  logic              wr_ctl;
  logic              wr_data;
  logic [7:0]        ctrl_q;
  logic              mreset;
  logic [1:0]        txc;
  logic              receiver_interrupt_enable;
  logic [7:0]        status_w;
  logic              irq_q;
  logic [7:0]        tdr_q;
  logic              transmit_empty_flag_q;
  asa_pkg::asa_fmt_s tf;
  logic [7:0]        tx_dm;
  logic              tx_par;
  logic [10:0]       tx_vec;
  logic [3:0]        tx_len;
  logic              tx_busy_q;
  logic [10:0]       tx_sh_q;
  logic [3:0]        tx_left_q;
  logic [5:0]        tx_cnt_q;
  logic              tx_line_q;
  logic              tx_line_d;
  logic              tx_take;
  logic              char_valid;
  logic [7:0]        char_data;
  logic              char_frame_err;
  logic              char_par_err;
  logic [7:0]        receive_holding_reg_q;
  logic              receive_full_flag_q;
  logic              framing_fault_flag_q;
  logic              parity_fault_flag_q;
  logic              overrun_flag_q;
  logic              ovr_pend_q;
  logic              car_latch_q;
  logic              car_seen_q;

  // Pins and bit clocks pass two flops; third flop only for edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_1_q <= asa_pkg::PIN_RESET;
      pin_2_q <= asa_pkg::PIN_RESET;
      pin_3_q <= asa_pkg::PIN_RESET;
    end else begin
      pin_1_q <= {carrier_present_input_n, clear_to_send_n, rxd,
                  receive_bit_clock, transmit_bit_clock};
      pin_2_q <= pin_1_q;
      pin_3_q <= pin_2_q;
    end
  end

  assign tx_fall  = !pin_2_q[asa_pkg::PIN_TXC] && pin_3_q[asa_pkg::PIN_TXC];
  assign rx_rise  = pin_2_q[asa_pkg::PIN_RXC] && !pin_3_q[asa_pkg::PIN_RXC];
  assign car_rise = pin_2_q[asa_pkg::PIN_CAR] && !pin_3_q[asa_pkg::PIN_CAR];
  assign cts_s    = pin_2_q[asa_pkg::PIN_CTS];
  assign car_s    = pin_2_q[asa_pkg::PIN_CAR];

  // Bus decode: one access per strobe cycle
  assign sel     = bus_strobe && chip_select_0 && chip_select_1 && !chip_select_2_n;
  assign rd_stat = sel && read_not_write && !register_select_line;
  assign wr_ctl  = sel && !read_not_write && !register_select_line;
  assign rd_data = sel && read_not_write && register_select_line;
  assign wr_data = sel && !read_not_write && register_select_line;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= asa_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctrl_q <= data_in;
    end
  end

  assign mreset = (ctrl_q[asa_pkg::DIV_MSB:asa_pkg::DIV_LSB] == asa_pkg::DIV_MRST);
  assign txc    = ctrl_q[asa_pkg::TXC_MSB:asa_pkg::TXC_LSB];
  assign receiver_interrupt_enable    = ctrl_q[asa_pkg::RIE_BIT];

  always_comb begin
    status_w                       = '0;
    status_w[asa_pkg::ST_FULL]     = receive_full_flag_q;
    status_w[asa_pkg::ST_EMPTY]    = transmit_empty_flag_q && !cts_s;
    status_w[asa_pkg::ST_CARRIER]  = car_latch_q || car_s;
    status_w[asa_pkg::ST_CTS]      = cts_s;
    status_w[asa_pkg::ST_FRAME]    = framing_fault_flag_q;
    status_w[asa_pkg::ST_OVR]      = overrun_flag_q;
    status_w[asa_pkg::ST_PAR]      = parity_fault_flag_q;
    status_w[asa_pkg::ST_IRQ]      = irq_q;
  end

  // Read data is held one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out  <= '0;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !(rd_stat || rd_data);
      if (rd_stat) begin
        data_out <= status_w;
      end else if (rd_data) begin
        data_out <= receive_holding_reg_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= !mreset && ((receiver_interrupt_enable && (receive_full_flag_q || car_latch_q))
               || (txc == asa_pkg::TXC_IRQ && status_w[asa_pkg::ST_EMPTY]));
    end
  end

  assign irq_out  = 1'b0;
  assign irq_oe_n = !irq_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      request_to_send_n <= 1'b1;
    end else begin
      request_to_send_n <= mreset || (txc == asa_pkg::TXC_HIGH);
    end
  end

  // Transmit frame assembly; parity sits after the last data bit
  assign tf = asa_pkg::asa_fmt(ctrl_q[asa_pkg::FMT_MSB:asa_pkg::FMT_LSB]);

  always_comb begin
    tx_dm  = tf.eight ? tdr_q : {1'b0, tdr_q[6:0]};
    tx_par = (^tx_dm) ^ tf.odd;
    if (!tf.eight) begin
      tx_vec = {asa_pkg::MARK_FILL, tx_par, tx_dm[6:0]};
    end else if (tf.par_en) begin
      tx_vec = {asa_pkg::MARK_FILL[1:0], tx_par, tx_dm};
    end else begin
      tx_vec = {asa_pkg::MARK_FILL, tx_dm};
    end
    tx_len = asa_pkg::asa_nbits(tf) + {3'h0, tf.par_en}
             + (tf.two_stop ? asa_pkg::STOP_2 : asa_pkg::STOP_1);
  end

  // Next character starts at once if loaded before the last stop ends
  assign tx_take = tx_fall && !mreset && !transmit_empty_flag_q
                   && (!tx_busy_q || (tx_cnt_q == '0 && tx_left_q == '0));

  always_comb begin
    tx_line_d = tx_line_q;
    if (tx_take) begin
      tx_line_d = 1'b0;
    end else if (tx_busy_q && tx_cnt_q == '0) begin
      tx_line_d = (tx_left_q == '0) ? 1'b1 : tx_sh_q[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= '0;
      tx_left_q <= '0;
      tx_cnt_q  <= '0;
      tx_line_q <= 1'b1;
      txd       <= 1'b1;
    end else if (tx_fall) begin
      if (mreset) begin
        tx_busy_q <= 1'b0;
        tx_line_q <= 1'b1;
        txd       <= 1'b1;
      end else begin
        tx_line_q <= tx_line_d;
        // Break forces space but the shifter keeps its place
        txd <= (txc == asa_pkg::TXC_BRK) ? 1'b0 : tx_line_d;
        if (tx_take) begin
          tx_busy_q <= 1'b1;
          tx_sh_q   <= tx_vec;
          tx_left_q <= tx_len;
          tx_cnt_q  <= asa_pkg::asa_ticks(ctrl_q[asa_pkg::DIV_MSB:asa_pkg::DIV_LSB]);
        end else if (tx_busy_q && tx_cnt_q == '0) begin
          if (tx_left_q == '0) begin
            tx_busy_q <= 1'b0;
          end else begin
            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
            tx_left_q <= tx_left_q - 4'h1;
            tx_cnt_q  <= asa_pkg::asa_ticks(ctrl_q[asa_pkg::DIV_MSB:asa_pkg::DIV_LSB]);
          end
        end else if (tx_busy_q) begin
          tx_cnt_q <= tx_cnt_q - 6'h01;
        end
      end
    end
  end

  // A write in the transfer cycle wins: the new byte waits its turn
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tdr_q                 <= '0;
      transmit_empty_flag_q <= 1'b1;
    end else begin
      if (wr_data) begin
        tdr_q                 <= data_in;
        transmit_empty_flag_q <= 1'b0;
      end else if (tx_take || mreset) begin
        transmit_empty_flag_q <= 1'b1;
      end
    end
  end

  asa_rx u_rx (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .init           (mreset || car_s),
    .tick           (rx_rise),
    .rxd_s          (pin_2_q[asa_pkg::PIN_RXD]),
    .div            (ctrl_q[asa_pkg::DIV_MSB:asa_pkg::DIV_LSB]),
    .fmt            (ctrl_q[asa_pkg::FMT_MSB:asa_pkg::FMT_LSB]),
    .char_valid     (char_valid),
    .char_data      (char_data),
    .char_frame_err (char_frame_err),
    .char_par_err   (char_par_err)
  );

  // Receive holding and flags; a lost character leaves the held one intact
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      receive_holding_reg_q <= '0;
      receive_full_flag_q   <= 1'b0;
      framing_fault_flag_q  <= 1'b0;
      parity_fault_flag_q   <= 1'b0;
      overrun_flag_q        <= 1'b0;
      ovr_pend_q            <= 1'b0;
    end else if (mreset) begin
      receive_full_flag_q  <= 1'b0;
      framing_fault_flag_q <= 1'b0;
      parity_fault_flag_q  <= 1'b0;
      overrun_flag_q       <= 1'b0;
      ovr_pend_q           <= 1'b0;
    end else if (car_s) begin
      receive_full_flag_q <= 1'b0;
      overrun_flag_q      <= 1'b0;
      ovr_pend_q          <= 1'b0;
    end else begin
      if (rd_data) begin
        if (ovr_pend_q) begin
          overrun_flag_q <= 1'b1;
          ovr_pend_q     <= 1'b0;
        end else begin
          overrun_flag_q      <= 1'b0;
          receive_full_flag_q <= 1'b0;
        end
      end
      if (char_valid) begin
        if (!receive_full_flag_q || (rd_data && !ovr_pend_q)) begin
          receive_holding_reg_q <= char_data;
          receive_full_flag_q   <= 1'b1;
          framing_fault_flag_q  <= char_frame_err;
          parity_fault_flag_q   <= char_par_err;
        end else begin
          ovr_pend_q <= 1'b1;
        end
      end
    end
  end

  // Carrier loss latch: cleared by status read then data read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      car_latch_q <= 1'b0;
      car_seen_q  <= 1'b0;
    end else begin
      if (mreset || (rd_data && car_seen_q)) begin
        car_latch_q <= 1'b0;
        car_seen_q  <= 1'b0;
      end else if (rd_stat && car_latch_q) begin
        car_seen_q <= 1'b1;
      end
      if (car_rise) begin
        car_latch_q <= 1'b1;
        car_seen_q  <= 1'b0;
      end
    end
  end

  a_txd_on_fall: assert property (
    @(posedge ref_clk) disable iff (rst) $changed(txd) |-> $past(tx_fall)
  ) else $error("transmit line moved without a clock fall");

  a_cts_hides_empty: assert property (
    @(posedge ref_clk) disable iff (rst) rd_stat && cts_s |=> !data_out[asa_pkg::ST_EMPTY]
  ) else $error("empty flag shown while clear-to-send high");

  a_cts_status: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_stat |=> data_out[asa_pkg::ST_CTS] == $past(cts_s)
  ) else $error("status bit 3 differs from clear-to-send");

  a_rts_follow: assert property (
    @(posedge ref_clk) disable iff (rst)
    !mreset |=> request_to_send_n == ($past(txc) == asa_pkg::TXC_HIGH)
  ) else $error("request-to-send disagrees with control");

  a_carrier_irq: assert property (
    @(posedge ref_clk) disable iff (rst)
    car_rise && receiver_interrupt_enable && !mreset && !wr_ctl |-> ##2 !irq_oe_n
  ) else $error("carrier loss did not raise interrupt");

  a_read_clears_full: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_data && !ovr_pend_q && !char_valid |=> !receive_full_flag_q
  ) else $error("data read left receive full set");

  a_write_fills: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data |=> !transmit_empty_flag_q [*1] ##0 !status_w[asa_pkg::ST_EMPTY]
  ) else $error("transmit write did not clear empty");

  a_overrun_late: assert property (
    @(posedge ref_clk) disable iff (rst)
    char_valid && receive_full_flag_q && !rd_data && !overrun_flag_q && !mreset && !car_s
    |=> ovr_pend_q && !overrun_flag_q && receive_full_flag_q
  ) else $error("overrun shown before prior character read");

  a_irq_status: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_stat |=> data_out[asa_pkg::ST_IRQ] == !$past(irq_oe_n)
  ) else $error("status bit 7 differs from interrupt output");

  a_break_space: assert property (
    @(posedge ref_clk) disable iff (rst)
    tx_fall && !mreset && txc == asa_pkg::TXC_BRK |=> !txd
  ) else $error("break selected but line not at space");

endmodule : asa_core

/* core/asa_pkg.sv */
// Constants and decode helpers shared by the async serial adapter
package asa_pkg;

  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 1;
  localparam int FMT_LSB = 2;
  localparam int FMT_MSB = 4;
  localparam int TXC_LSB = 5;
  localparam int TXC_MSB = 6;
  localparam int RIE_BIT = 7;

  localparam int ST_FULL    = 0;
  localparam int ST_EMPTY   = 1;
  localparam int ST_CARRIER = 2;
  localparam int ST_CTS     = 3;
  localparam int ST_FRAME   = 4;
  localparam int ST_OVR     = 5;
  localparam int ST_PAR     = 6;
  localparam int ST_IRQ     = 7;

  localparam int PIN_TXC = 0;
  localparam int PIN_RXC = 1;
  localparam int PIN_RXD = 2;
  localparam int PIN_CTS = 3;
  localparam int PIN_CAR = 4;
  localparam logic [4:0] PIN_RESET = 5'h1f;

  // Power-up holds the master reset code until software writes another
  localparam logic [7:0] CTL_RESET = 8'h03;

  localparam logic [1:0] DIV_1    = 2'h0;
  localparam logic [1:0] DIV_16   = 2'h1;
  localparam logic [1:0] DIV_64   = 2'h2;
  localparam logic [1:0] DIV_MRST = 2'h3;

  localparam logic [1:0] TXC_LOW  = 2'h0;
  localparam logic [1:0] TXC_IRQ  = 2'h1;
  localparam logic [1:0] TXC_HIGH = 2'h2;
  localparam logic [1:0] TXC_BRK  = 2'h3;

  // Ticks per bit minus one, and start-bit half minus two
  localparam logic [5:0] TK_1    = 6'h00;
  localparam logic [5:0] TK_16   = 6'h0f;
  localparam logic [5:0] TK_64   = 6'h3f;
  localparam logic [5:0] HALF_16 = 6'h06;
  localparam logic [5:0] HALF_64 = 6'h1e;

  localparam logic [3:0] NBITS_7   = 4'h7;
  localparam logic [3:0] NBITS_8   = 4'h8;
  localparam logic [3:0] STOP_1    = 4'h1;
  localparam logic [3:0] STOP_2    = 4'h2;
  localparam logic [2:0] MARK_FILL = 3'h7;

  typedef struct packed {
    logic eight;
    logic par_en;
    logic odd;
    logic two_stop;
  } asa_fmt_s;

  function automatic asa_fmt_s asa_fmt(input logic [2:0] w);
    unique case (w)
      3'h0:    return '{1'b0, 1'b1, 1'b0, 1'b1};
      3'h1:    return '{1'b0, 1'b1, 1'b1, 1'b1};
      3'h2:    return '{1'b0, 1'b1, 1'b0, 1'b0};
      3'h3:    return '{1'b0, 1'b1, 1'b1, 1'b0};
      3'h4:    return '{1'b1, 1'b0, 1'b0, 1'b1};
      3'h5:    return '{1'b1, 1'b0, 1'b0, 1'b0};
      3'h6:    return '{1'b1, 1'b1, 1'b0, 1'b0};
      default: return '{1'b1, 1'b1, 1'b1, 1'b0};
    endcase
  endfunction : asa_fmt

  function automatic logic [5:0] asa_ticks(input logic [1:0] d);
    unique case (d)
      DIV_16:  return TK_16;
      DIV_64:  return TK_64;
      default: return TK_1;
    endcase
  endfunction : asa_ticks

  function automatic logic [5:0] asa_half(input logic [1:0] d);
    return (d == DIV_64) ? HALF_64 : HALF_16;
  endfunction : asa_half

  function automatic logic [3:0] asa_nbits(input asa_fmt_s f);
    return f.eight ? NBITS_8 : NBITS_7;
  endfunction : asa_nbits

endpackage : asa_pkg

/* core/asa_rx.sv */
`timescale 1ns/1ps
// Receive deserializer: start detection, bit sampling, character checks
module asa_rx (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       init,
  input  wire logic       tick,
  input  wire logic       rxd_s,
  input  wire logic [1:0] div,
  input  wire logic [2:0] fmt,
  output logic            char_valid,
  output logic [7:0]      char_data,
  output logic            char_frame_err,
  output logic            char_par_err
);

  typedef enum logic [2:0] {
    ASA_RX_IDLE  = 3'b001,
    ASA_RX_START = 3'b010,
    ASA_RX_BITS  = 3'b100
  } asa_rx_state_e;

  asa_rx_state_e     state_q;
  logic [5:0]        cnt_q;
  logic [3:0]        idx_q;
  logic [7:0]        shift_q;
  logic              pbit_q;
  asa_pkg::asa_fmt_s f;
  logic [3:0]        nd;
  logic [7:0]        data_w;
  logic              last;

  assign f      = asa_pkg::asa_fmt(fmt);
  assign nd     = asa_pkg::asa_nbits(f);
  assign data_w = f.eight ? shift_q : {1'b0, shift_q[7:1]};
  assign last   = (idx_q == nd + {3'h0, f.par_en});

  always_ff @(posedge ref_clk) begin
    if (rst || init) begin
      state_q        <= ASA_RX_IDLE;
      cnt_q          <= '0;
      idx_q          <= '0;
      shift_q        <= '0;
      pbit_q         <= 1'b0;
      char_valid     <= 1'b0;
      char_data      <= '0;
      char_frame_err <= 1'b0;
      char_par_err   <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      if (tick) begin
        unique case (state_q)
          ASA_RX_IDLE: begin
            if (!rxd_s) begin
              idx_q <= '0;
              if (div == asa_pkg::DIV_1) begin
                // No alignment: far end keeps data in step with the clock
                state_q <= ASA_RX_BITS;
                cnt_q   <= asa_pkg::TK_1;
              end else begin
                state_q <= ASA_RX_START;
                cnt_q   <= asa_pkg::asa_half(div);
              end
            end
          end
          ASA_RX_START: begin
            // Start must stay low for half a bit, else it was noise
            if (rxd_s) begin
              state_q <= ASA_RX_IDLE;
            end else if (cnt_q == '0) begin
              state_q <= ASA_RX_BITS;
              cnt_q   <= asa_pkg::asa_ticks(div);
            end else begin
              cnt_q <= cnt_q - 6'h01;
            end
          end
          ASA_RX_BITS: begin
            if (cnt_q != '0) begin
              cnt_q <= cnt_q - 6'h01;
            end else begin
              cnt_q <= asa_pkg::asa_ticks(div);
              idx_q <= idx_q + 4'h1;
              if (idx_q < nd) begin
                shift_q <= {rxd_s, shift_q[7:1]};
              end else if (!last) begin
                pbit_q <= rxd_s;
              end else begin
                state_q        <= ASA_RX_IDLE;
                char_valid     <= 1'b1;
                char_data      <= data_w;
                char_frame_err <= !rxd_s;
                char_par_err   <= f.par_en && ((^data_w ^ pbit_q) != f.odd);
              end
            end
          end
        endcase
      end
    end
  end

  a_rx_on_tick: assert property (
    @(posedge ref_clk) disable iff (rst)
    !tick && !init |=> $stable(shift_q) && $stable(idx_q)
  ) else $error("receiver moved without a receive clock rise");

  a_rx_char_tick: assert property (
    @(posedge ref_clk) disable iff (rst)
    char_valid |-> $past(tick) && ($past(state_q) == ASA_RX_BITS)
  ) else $error("character completed outside a stop bit sample");

endmodule : asa_rx

/* bench/asa_modem.sv */
`timescale 1ns/1ps
// Far-side modem model: bit clock, serial receive driver, transmit capture
module asa_modem (
  output logic       bclk,
  output logic       rxd,
  input  wire logic  txd,
  output logic [7:0] got,
  output int         n
);
  logic [3:0] k;
  logic [7:0] sh;

  initial begin
    bclk = 1'b0;
    rxd = 1'b1;
    n = 0;
    got = 8'h00;
    k = 4'h0;
    sh = 8'h00;
    // Free running, five ref_clk per half period
    forever #200 bclk = ~bclk;
  end

  // Mid-bit capture; device moves txd only on falls
  always @(posedge bclk) begin
    if (k == 4'h0) begin
      if (txd === 1'b0) k <= 4'h1;
    end else if (k < 4'h9) begin
      sh <= {txd, sh[7:1]};
      k <= k + 4'h1;
    end else begin
      got <= sh;
      n <= n + 1;
      k <= 4'h0;
    end
  end

  // Data moves on falls, so it is stable at each rise
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge bclk);
      rxd <= f[i];
    end
  endtask : send
endmodule : asa_modem

/* bench/asa_core_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the async serial adapter core
module asa_core_tb;
  logic       ref_clk, rst, stb, rnw, rs, cts_n, car_n, cs0, cs1, cs2_n;
  logic [7:0] din, dout, q, got;
  logic       doe_n, irq, irq_oe_n, bclk, rxd, txd, rts_n;
  int         n;
  int         miscompares = 0;
  int         total_checks = 0;

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  asa_modem modem (.bclk(bclk), .rxd(rxd), .txd(txd), .got(got), .n(n));

  asa_core dut (
    .ref_clk(ref_clk), .rst(rst), .bus_strobe(stb), .chip_select_0(cs0),
    .chip_select_1(cs1), .chip_select_2_n(cs2_n), .read_not_write(rnw),
    .register_select_line(rs), .data_in(din), .data_out(dout), .data_oe_n(doe_n),
    .irq_out(irq), .irq_oe_n(irq_oe_n), .transmit_bit_clock(bclk),
    .receive_bit_clock(bclk), .rxd(rxd), .txd(txd), .clear_to_send_n(cts_n),
    .request_to_send_n(rts_n), .carrier_present_input_n(car_n)
  );

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One strobed access; read data lands on the same edge that takes the strobe
  task automatic acc(input logic r, input logic s, input logic [7:0] d);
    @(posedge ref_clk);
    stb <= 1'b1;
    rnw <= r;
    rs <= s;
    din <= d;
    @(posedge ref_clk);
    stb <= 1'b0;
    #1 q = dout;
    chk({7'h0, doe_n}, {7'h0, !r});
  endtask : acc

  task automatic poll(input logic [7:0] m);
    for (int i = 0; i < 100; i++) begin
      acc(1'b1, 1'b0, 8'h00);
      if ((q & m) !== 8'h00) break;
    end
  endtask : poll

  task automatic wait_char(input int k, input logic [7:0] e);
    for (int i = 0; i < 600 && n < k; i++) @(posedge ref_clk);
    chk(got, e);
  endtask : wait_char

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Whole run needs well under 100 us
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  initial begin
    {rst, cs0, cs1} = 3'b111;
    {stb, rnw, rs, cs2_n, cts_n, car_n} = 6'h00;
    din = 8'h00;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    // Software reset first; also lets the pin synchronisers settle
    acc(1'b0, 1'b0, 8'h03);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h02);
    acc(1'b0, 1'b0, 8'h14);
    acc(1'b0, 1'b1, 8'ha5);
    chk({7'h0, rts_n}, 8'h00);
    poll(8'h02);
    acc(1'b0, 1'b1, 8'h5a);
    acc(1'b1, 1'b0, 8'h00);
    chk(q & 8'h02, 8'h00);
    wait_char(1, 8'ha5);
    wait_char(2, 8'h5a);
    modem.send(8'h3c);
    poll(8'h01);
    chk(q, 8'h03);
    acc(1'b1, 1'b1, 8'h00);
    chk(q, 8'h3c);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h02);
    // Two characters unread: second is lost, overrun shows after one read
    modem.send(8'h11);
    modem.send(8'h22);
    repeat (12) @(posedge ref_clk);
    acc(1'b1, 1'b1, 8'h00);
    chk(q, 8'h11);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h23);
    acc(1'b1, 1'b1, 8'h00);
    chk(q, 8'h11);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h02);
    // Seven bits, even parity, one stop
    acc(1'b0, 1'b0, 8'h08);
    modem.send(8'hc3);
    poll(8'h01);
    chk(q, 8'h03);
    acc(1'b1, 1'b1, 8'h00);
    chk(q, 8'h43);
    modem.send(8'h43);
    poll(8'h01);
    chk(q, 8'h43);
    acc(1'b1, 1'b1, 8'h00);
    chk(q, 8'h43);
    acc(1'b0, 1'b1, 8'h43);
    wait_char(3, 8'hc3);
    // Parity flag outlives the read; master reset clears it
    acc(1'b0, 1'b0, 8'h03);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h02);
    acc(1'b0, 1'b0, 8'h14);
    cts_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h08);
    cts_n <= 1'b0;
    acc(1'b0, 1'b0, 8'h94);
    car_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h86);
    chk({7'h0, irq_oe_n}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    car_n <= 1'b0;
    acc(1'b1, 1'b1, 8'h00);
    acc(1'b1, 1'b0, 8'h00);
    chk(q, 8'h02);
    chk({7'h0, irq_oe_n}, 8'h01);
    acc(1'b0, 1'b0, 8'h74);
    repeat (15) @(negedge ref_clk);
    chk({7'h0, txd}, 8'h00);
    acc(1'b0, 1'b0, 8'h54);
    repeat (2) @(negedge ref_clk);
    chk({7'h0, rts_n}, 8'h01);
    summarize();
  end
endmodule : asa_core_tb
